// file: src/tor_irq_bank.sv
`timescale 1ns/1ps
`include "tor_map.svh"

module tor_irq_bank (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// timer events, one-cycle pulses
	input wire logic updateEvt,
	input wire logic triggerEvt,
	input wire logic [3:0] ccEvt,
	// software writes
	input wire logic wrEnable,
	input wire logic wrClear,
	input wire logic wrMissed,
	input wire logic [31:0] wdata,
	// state
	output logic [`TOR_IRQ_W-1:0] enable_q,
	output logic [`TOR_IRQ_W-1:0] pending_q,
	output logic [3:0] missed_q,
	output logic irqReq_q
);

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	logic [`TOR_IRQ_W-1:0] evtVec;
	logic [`TOR_IRQ_W-1:0] clrVec;
	logic [`TOR_IRQ_W-1:0] enable_d;
	logic [`TOR_IRQ_W-1:0] pending_d;
	logic [3:0] missed_d;

	always_comb begin
		evtVec = `TOR_RST_IRQ;
		evtVec[`TOR_BIT_UPDATE] = updateEvt;
		evtVec[`TOR_BIT_TRIG] = triggerEvt;
		evtVec[`TOR_BIT_CC1 +: 4] = ccEvt;
		clrVec = wrClear ? wdata[`TOR_IRQ_W-1:0] : `TOR_RST_IRQ;
		enable_d = wrEnable ? (wdata[`TOR_IRQ_W-1:0] & `TOR_IRQ_MASK)
			: enable_q;
		// a new event wins over a clear in the same cycle
		pending_d = ((pending_q & ~clrVec) | evtVec) & `TOR_IRQ_MASK;
	end

	// ----------------------------------------------------------------
	// missed marks, one per channel
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_miss
			logic missSet;
			logic missClr;
			assign missSet = ccEvt[gi] & pending_q[`TOR_BIT_CC1 + gi];
			assign missClr = wrMissed & wdata[`TOR_MISS_LSB + gi];
			assign missed_d[gi] = missSet | (missed_q[gi] & ~missClr);
		end
	endgenerate

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enable_q <= `TOR_RST_IRQ;
		end else begin
			enable_q <= enable_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pending_q <= `TOR_RST_IRQ;
			missed_q <= `TOR_RST_MISS;
		end else begin
			pending_q <= pending_d;
			missed_q <= missed_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irqReq_q <= 1'b0;
		end else begin
			irqReq_q <= |(pending_d & enable_d);
		end
	end

endmodule : tor_irq_bank

// file: src/tor_map.svh
`ifndef TOR_MAP_SVH
`define TOR_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define TOR_ADDR_T1_PEND 32'h4000a800
`define TOR_ADDR_T2_PEND 32'h4000a804
`define TOR_ADDR_T1_MISS 32'h4000a818
`define TOR_ADDR_T2_MISS 32'h4000a81c
`define TOR_ADDR_T1_EN 32'h4000a840
`define TOR_ADDR_T2_EN 32'h4000a844
`define TOR_ADDR_OPT 32'h4000f050
`define TOR_ADDR_T1_CLR 32'h4000a880
`define TOR_ADDR_T2_CLR 32'h4000a884

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TOR_IRQ_W 7
`define TOR_BIT_UPDATE 0
`define TOR_BIT_CC1 1
`define TOR_BIT_TRIG 6
`define TOR_IRQ_MASK 7'h5f
`define TOR_MISS_LSB 9
`define TOR_OPT_ALT_LSB 4
`define TOR_OPT_RSVD 3
`define TOR_OPT_GATE 2
`define TOR_OPT_SEL_LSB 0
`define TOR_OPT_W 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TOR_RST_IRQ 7'h00
`define TOR_RST_MISS 4'h0
`define TOR_RST_OPT 8'h00
`define TOR_RST_WORD 32'h00000000

`endif

// file: src/tor_pkg.sv
package tor_pkg;

	typedef enum logic [1:0] {
		TOR_TRIG_PCLK = 2'h0,
		TOR_TRIG_1K = 2'h1,
		TOR_TRIG_32K = 2'h2,
		TOR_TRIG_PIN = 2'h3
	} tor_trig_t;

	typedef enum logic [9:0] {
		TOR_SEL_NONE = 10'h001,
		TOR_SEL_T1_PEND = 10'h002,
		TOR_SEL_T2_PEND = 10'h004,
		TOR_SEL_T1_MISS = 10'h008,
		TOR_SEL_T2_MISS = 10'h010,
		TOR_SEL_T1_EN = 10'h020,
		TOR_SEL_T2_EN = 10'h040,
		TOR_SEL_OPT = 10'h080,
		TOR_SEL_T1_CLR = 10'h100,
		TOR_SEL_T2_CLR = 10'h200
	} tor_sel_t;

endpackage : tor_pkg

// file: src/tor_top.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "tor_map.svh"

module tor_top (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// timer 1 events from the counter core
	input wire logic t1UpdateEvt,
	input wire logic t1TriggerEvt,
	input wire logic [3:0] t1CcEvt,
	// timer 2 events from the counter core
	input wire logic t2UpdateEvt,
	input wire logic t2TriggerEvt,
	input wire logic [3:0] t2CcEvt,
	// trigger sources, asynchronous
	input wire logic tick1kIn,
	input wire logic ref32kIn,
	input wire logic ext_clock_pin,
	input wire logic ext_clock_gate_input,
	// option outputs
	output logic [3:0] chanPinAlt_q,
	output logic extTriggerTick_q,
	// interrupts
	output logic timer1Irq_q,
	output logic timer2Irq_q,
	output logic irq_q
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic tor_pkg::tor_sel_t decodeAddr(
		input logic [31:0] addr
	);
		case (addr)
			`TOR_ADDR_T1_PEND: decodeAddr = tor_pkg::TOR_SEL_T1_PEND;
			`TOR_ADDR_T2_PEND: decodeAddr = tor_pkg::TOR_SEL_T2_PEND;
			`TOR_ADDR_T1_MISS: decodeAddr = tor_pkg::TOR_SEL_T1_MISS;
			`TOR_ADDR_T2_MISS: decodeAddr = tor_pkg::TOR_SEL_T2_MISS;
			`TOR_ADDR_T1_EN: decodeAddr = tor_pkg::TOR_SEL_T1_EN;
			`TOR_ADDR_T2_EN: decodeAddr = tor_pkg::TOR_SEL_T2_EN;
			`TOR_ADDR_OPT: decodeAddr = tor_pkg::TOR_SEL_OPT;
			`TOR_ADDR_T1_CLR: decodeAddr = tor_pkg::TOR_SEL_T1_CLR;
			`TOR_ADDR_T2_CLR: decodeAddr = tor_pkg::TOR_SEL_T2_CLR;
			default: decodeAddr = tor_pkg::TOR_SEL_NONE;
		endcase
	endfunction : decodeAddr

	// ----------------------------------------------------------------
	// bus phases
	// ----------------------------------------------------------------
	logic addrPhase;
	tor_pkg::tor_sel_t addrSel;
	tor_pkg::tor_sel_t dpSel_q;
	logic dpWrite_q;

	assign addrPhase = hsel & hready & htrans[1];
	assign addrSel = decodeAddr(haddr);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dpWrite_q <= 1'b0;
			dpSel_q <= tor_pkg::TOR_SEL_NONE;
		end else if (hready) begin
			dpWrite_q <= addrPhase & hwrite;
			dpSel_q <= addrPhase ? addrSel : tor_pkg::TOR_SEL_NONE;
		end
	end

	// zero wait states, always okay
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// write strobes
	// ----------------------------------------------------------------
	logic wrT1Pend;
	logic wrT2Pend;
	logic wrT1Miss;
	logic wrT2Miss;
	logic wrT1En;
	logic wrT2En;
	logic wrOpt;
	logic wrT1Clr;
	logic wrT2Clr;

	assign wrT1Pend = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_T1_PEND);
	assign wrT2Pend = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_T2_PEND);
	assign wrT1Miss = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_T1_MISS);
	assign wrT2Miss = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_T2_MISS);
	assign wrT1En = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_T1_EN);
	assign wrT2En = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_T2_EN);
	assign wrOpt = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_OPT);
	assign wrT1Clr = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_T1_CLR);
	assign wrT2Clr = dpWrite_q & (dpSel_q == tor_pkg::TOR_SEL_T2_CLR);

	// ----------------------------------------------------------------
	// option register
	// ----------------------------------------------------------------
	logic [`TOR_OPT_W-1:0] option_q;
	tor_pkg::tor_trig_t trigSel;
	logic gateEn;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			option_q <= `TOR_RST_OPT;
		end else if (wrOpt) begin
			// the reserved bit is kept but steers nothing
			option_q <= hwdata[`TOR_OPT_W-1:0];
		end
	end

	assign trigSel = tor_pkg::tor_trig_t'(option_q[`TOR_OPT_SEL_LSB +: 2]);
	assign gateEn = option_q[`TOR_OPT_GATE];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chanPinAlt_q <= 4'h0;
		end else begin
			chanPinAlt_q <= option_q[`TOR_OPT_ALT_LSB +: 4];
		end
	end

	// ----------------------------------------------------------------
	// trigger source synchronisers
	// ----------------------------------------------------------------
	localparam int NSRC = 4;
	logic [NSRC-1:0] srcRaw;
	logic [NSRC-1:0] srcMeta_q;
	logic [NSRC-1:0] srcSync_q;

	assign srcRaw = {ext_clock_gate_input, ext_clock_pin, ref32kIn, tick1kIn};

	genvar gs;
	generate
		for (gs = 0; gs < NSRC; gs++) begin : g_sync
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					srcMeta_q[gs] <= 1'b0;
					srcSync_q[gs] <= 1'b0;
				end else begin
					srcMeta_q[gs] <= srcRaw[gs];
					srcSync_q[gs] <= srcMeta_q[gs];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// trigger selection
	// ----------------------------------------------------------------
	logic pinLevel;
	logic selLevel;
	logic selPrev_q;
	logic trigTick;

	// mask input only matters when gating is on
	assign pinLevel = srcSync_q[2] & (~gateEn | srcSync_q[3]);

	always_comb begin
		case (trigSel)
			tor_pkg::TOR_TRIG_1K: selLevel = srcSync_q[0];
			tor_pkg::TOR_TRIG_32K: selLevel = srcSync_q[1];
			tor_pkg::TOR_TRIG_PIN: selLevel = pinLevel;
			default: selLevel = 1'b1;
		endcase
	end

	// peripheral clock ticks every cycle, others on rising edges
	assign trigTick = (trigSel == tor_pkg::TOR_TRIG_PCLK) |
		(selLevel & ~selPrev_q);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			selPrev_q <= 1'b0;
			extTriggerTick_q <= 1'b0;
		end else begin
			selPrev_q <= selLevel;
			extTriggerTick_q <= trigTick;
		end
	end

	// ----------------------------------------------------------------
	// interrupt banks
	// ----------------------------------------------------------------
	logic [`TOR_IRQ_W-1:0] t1En;
	logic [`TOR_IRQ_W-1:0] t1Pend;
	logic [3:0] t1Miss;
	logic [`TOR_IRQ_W-1:0] t2En;
	logic [`TOR_IRQ_W-1:0] t2Pend;
	logic [3:0] t2Miss;

	tor_irq_bank u_bank1 (
		.clk(clk),
		.arst_n(arst_n),
		.updateEvt(t1UpdateEvt),
		.triggerEvt(t1TriggerEvt),
		.ccEvt(t1CcEvt),
		.wrEnable(wrT1En),
		.wrClear(wrT1Pend | wrT1Clr),
		.wrMissed(wrT1Miss),
		.wdata(hwdata),
		.enable_q(t1En),
		.pending_q(t1Pend),
		.missed_q(t1Miss),
		.irqReq_q(timer1Irq_q)
	);

	tor_irq_bank u_bank2 (
		.clk(clk),
		.arst_n(arst_n),
		.updateEvt(t2UpdateEvt),
		.triggerEvt(t2TriggerEvt),
		.ccEvt(t2CcEvt),
		.wrEnable(wrT2En),
		.wrClear(wrT2Pend | wrT2Clr),
		.wrMissed(wrT2Miss),
		.wdata(hwdata),
		.enable_q(t2En),
		.pending_q(t2Pend),
		.missed_q(t2Miss),
		.irqReq_q(timer2Irq_q)
	);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= timer1Irq_q | timer2Irq_q;
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	logic [31:0] rdWord;

	// clear registers, unmapped addresses and bit 5 of pending and enable read as zero
	always_comb begin
		rdWord = `TOR_RST_WORD;
		case (addrSel)
			tor_pkg::TOR_SEL_T1_PEND: rdWord[`TOR_IRQ_W-1:0] = t1Pend;
			tor_pkg::TOR_SEL_T2_PEND: rdWord[`TOR_IRQ_W-1:0] = t2Pend;
			tor_pkg::TOR_SEL_T1_MISS: rdWord[`TOR_MISS_LSB +: 4] = t1Miss;
			tor_pkg::TOR_SEL_T2_MISS: rdWord[`TOR_MISS_LSB +: 4] = t2Miss;
			tor_pkg::TOR_SEL_T1_EN: rdWord[`TOR_IRQ_W-1:0] = t1En;
			tor_pkg::TOR_SEL_T2_EN: rdWord[`TOR_IRQ_W-1:0] = t2En;
			tor_pkg::TOR_SEL_OPT: rdWord[`TOR_OPT_W-1:0] = option_q;
			default: rdWord = `TOR_RST_WORD;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= `TOR_RST_WORD;
		end else if (addrPhase & ~hwrite) begin
			hrdata <= rdWord;
		end else if (addrPhase) begin
			hrdata <= `TOR_RST_WORD;
		end
	end

endmodule : tor_top

// file: verif/tor_top_bench.sv
`timescale 1ns/1ps
`include "tor_map.svh"

module tor_top_bench;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, irq_q, timer1Irq_q, timer2Irq_q, extTriggerTick_q;
	logic [31:0] hrdata;
	logic [3:0] chanPinAlt_q;
	logic [6:0] ev1 = 7'h0;
	logic [6:0] ev2 = 7'h0;
	logic [7:0] ph = 8'h0;
	logic gateIn = 1'b0;
	int n_fail = 0;
	int total_checks = 0;
	int ticks = 0;
	int i;
	typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} tor_row_t;
	tor_row_t rows [7] = '{
		'{`TOR_ADDR_T1_EN, 32'hffffffff, 32'h0000005f},
		'{`TOR_ADDR_T2_EN, 32'hffffffff, 32'h0000005f},
		'{`TOR_ADDR_OPT, 32'h000000a7, 32'h000000a7},
		'{`TOR_ADDR_T1_PEND, 32'hffffffff, 32'h0},
		'{`TOR_ADDR_T2_MISS, 32'hffffffff, 32'h0},
		'{`TOR_ADDR_T1_CLR, 32'h0000005f, 32'h0},
		'{32'h4000a8f0, 32'h12345678, 32'h0}
	};

	tor_top tor_top_inst (
		.clk(clk), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .t1UpdateEvt(ev1[0]), .t1TriggerEvt(ev1[6]),
		.t1CcEvt(ev1[4:1]), .t2UpdateEvt(ev2[0]), .t2TriggerEvt(ev2[6]),
		.t2CcEvt(ev2[4:1]), .tick1kIn(ph[3]), .ref32kIn(ph[2]),
		.ext_clock_pin(ph[4]), .ext_clock_gate_input(gateIn),
		.chanPinAlt_q(chanPinAlt_q), .extTriggerTick_q(extTriggerTick_q),
		.timer1Irq_q(timer1Irq_q), .timer2Irq_q(timer2Irq_q), .irq_q(irq_q)
	);

	initial forever #20 clk = ~clk;
	// trigger sources rise every 16, 8 and 32 cycles
	always @(posedge clk) ph <= ph + 8'h1;
	always @(posedge clk) if (extTriggerTick_q) ticks <= ticks + 1;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic [31:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		r = hrdata;
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'b1, d, r);
	endtask : wr

	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(a, 1'b0, 32'h0, r);
		chk(r, e);
	endtask : rdchk

	task automatic evt(input int t, input int b);
		@(posedge clk);
		if (t == 1) ev1[b] <= 1'b1;
		else ev2[b] <= 1'b1;
		@(posedge clk);
		ev1 <= 7'h0;
		ev2 <= 7'h0;
	endtask : evt

	task automatic trig(input logic [7:0] opt, input logic g, input int e);
		int t0;
		wr(`TOR_ADDR_OPT, {24'h0, opt});
		gateIn <= g;
		repeat (8) @(posedge clk);
		t0 = ticks;
		repeat (128) @(posedge clk);
		total_checks++;
		if (ticks - t0 < e - 1 || ticks - t0 > e + 1) begin
			n_fail++;
			$display("ERROR %0t: %0d ticks, want %0d", $time, ticks - t0, e);
		end
		chk({28'h0, chanPinAlt_q}, {28'h0, opt[7:4]});
	endtask : trig

	task automatic conclude;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		#800000;
		n_fail++;
		$display("ERROR %0t: timeout", $time);
		conclude();
	end

	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		for (i = 0; i < 7; i++) begin
			wr(rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].e);
		end
		chk({28'h0, chanPinAlt_q}, 32'ha);
		$display("register rows done");
		// option bit 3 is always written as zero
		trig(8'h50, 1'b0, 128);
		trig(8'ha1, 1'b0, 8);
		trig(8'h02, 1'b0, 16);
		trig(8'hf3, 1'b0, 4);
		trig(8'h07, 1'b0, 0);
		trig(8'h07, 1'b1, 4);
		trig(8'h06, 1'b0, 16);
		$display("trigger tests done");
		for (i = 0; i < 7; i++) if (i != 5) begin
			evt(1, i);
			evt(2, i);
			@(negedge clk);
			chk({31'h0, irq_q}, 32'h1);
			rdchk(`TOR_ADDR_T1_PEND, 32'h1 << i);
			rdchk(`TOR_ADDR_T2_PEND, 32'h1 << i);
			if (i inside {[1:4]}) begin
				evt(1, i);
				rdchk(`TOR_ADDR_T1_MISS, 32'h100 << i);
				wr(`TOR_ADDR_T1_MISS, 32'h100 << i);
				rdchk(`TOR_ADDR_T1_MISS, 32'h0);
			end
			wr(`TOR_ADDR_T1_PEND, 32'h1 << i);
			wr(`TOR_ADDR_T2_CLR, 32'h1 << i);
			@(negedge clk);
			chk({30'h0, timer1Irq_q, timer2Irq_q}, 32'h0);
		end
		wr(`TOR_ADDR_T1_EN, 32'h0);
		evt(1, 6);
		@(negedge clk);
		chk({31'h0, timer1Irq_q}, 32'h0);
		rdchk(`TOR_ADDR_T1_PEND, 32'h40);
		wr(`TOR_ADDR_T1_EN, 32'h40);
		@(negedge clk);
		chk({31'h0, timer1Irq_q}, 32'h1);
		$display("event tests done");
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk({27'h0, chanPinAlt_q, irq_q}, 32'h0);
		for (i = 0; i < 7; i++) rdchk(rows[i].a, 32'h0);
		rdchk(`TOR_ADDR_T1_MISS, 32'h0);
		$display("reset test done");
		conclude();
	end
endmodule : tor_top_bench

// file: verif/tor_top_monitor.sv
`timescale 1ns/1ps
`include "tor_map.svh"

module tor_top_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// bus
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// events
	input wire logic t1UpdateEvt,
	input wire logic t1TriggerEvt,
	input wire logic [3:0] t1CcEvt,
	input wire logic t2UpdateEvt,
	input wire logic t2TriggerEvt,
	input wire logic [3:0] t2CcEvt,
	// outputs
	input wire logic [3:0] chanPinAlt_q,
	input wire logic timer1Irq_q,
	input wire logic timer2Irq_q,
	input wire logic irq_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic wrA;
	logic t1Evt;
	logic t2Evt;
	logic anyIrq;
	logic optWr;
	assign wrA = htrans[1] && hwrite;
	assign t1Evt = t1UpdateEvt | t1TriggerEvt | (|t1CcEvt);
	assign t2Evt = t2UpdateEvt | t2TriggerEvt | (|t2CcEvt);
	assign anyIrq = timer1Irq_q | timer2Irq_q;
	assign optWr = wrA && (haddr == `TOR_ADDR_OPT);

	a_irq_or_late: assert property (
		irq_q == $past(anyIrq))
		else $error("irq_q differs from delayed timer lines");
	a_t1_irq_cause: assert property (
		$rose(timer1Irq_q) |-> $past(t1Evt) || $past(wrA, 2))
		else $error("timer1 irq rose without cause");
	a_t2_irq_cause: assert property (
		$rose(timer2Irq_q) |-> $past(t2Evt) || $past(wrA, 2))
		else $error("timer2 irq rose without cause");
	a_t1_irq_sticky: assert property (
		$fell(timer1Irq_q) |-> $past(wrA, 2))
		else $error("timer1 irq fell without a write");
	a_t2_irq_sticky: assert property (
		$fell(timer2Irq_q) |-> $past(wrA, 2))
		else $error("timer2 irq fell without a write");
	a_pin_alt_write: assert property (
		$changed(chanPinAlt_q) |-> $past(optWr, 3) || $past(optWr, 2))
		else $error("channel pin choice changed without option write");
	a_rdata_holds: assert property (
		$changed(hrdata) |-> $past(htrans[1]))
		else $error("hrdata changed outside a transfer");
	a_reset_quiet: assert property (
		$rose(arst_n) |-> !irq_q && !timer1Irq_q && hreadyout && !hresp)
		else $error("outputs not quiet after reset");
endmodule : tor_top_monitor

bind tor_top tor_top_monitor tor_top_monitor_inst (
	.clk(clk), .arst_n(arst_n), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
	.t1UpdateEvt(t1UpdateEvt), .t1TriggerEvt(t1TriggerEvt),
	.t1CcEvt(t1CcEvt), .t2UpdateEvt(t2UpdateEvt),
	.t2TriggerEvt(t2TriggerEvt), .t2CcEvt(t2CcEvt),
	.chanPinAlt_q(chanPinAlt_q), .timer1Irq_q(timer1Irq_q),
	.timer2Irq_q(timer2Irq_q), .irq_q(irq_q)
);
